// file: design/bcc_pkg.sv
// Package: register map, field layout and cycle-length codes for the bus cycle control
package bcc_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] BCC_REG_OFFSET   = 8'h9d;
    localparam logic [7:0] BCC_REG_RESET    = 8'heb;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int         BCC_PFQ_BIT      = 7;
    localparam int         BCC_BC_BIT       = 6;
    localparam int         BCC_WR_LSB       = 4;
    localparam int         BCC_RD_LSB       = 2;
    localparam int         BCC_CODE_LSB     = 0;
    // ----------------------------------------
    // Cycle lengths in core-clock periods
    // ----------------------------------------
    localparam logic [2:0] BCC_DATA_BASE    = 3'h4;
    localparam logic [2:0] BCC_CODE_BASE    = 3'h3;
    localparam logic [2:0] BCC_CONST_MIN    = 3'h4;

    typedef enum logic [2:0] {
        BCC_KIND_FETCH = 3'h1,
        BCC_KIND_CONST = 3'h2,
        BCC_KIND_READ  = 3'h3,
        BCC_KIND_WRITE = 3'h4
    } bcc_kind_e;

    // Data cycles: code + 4 periods
    function automatic logic [2:0] bcc_data_len(input logic [1:0] code);
        bcc_data_len = BCC_DATA_BASE + {1'b0, code};
    endfunction

    // Code cycles: code + 3, constant reads never under 4
    function automatic logic [2:0] bcc_code_len(input logic [1:0] code, input logic is_const);
        logic [2:0] len;
        len = BCC_CODE_BASE + {1'b0, code};
        if (is_const && len < BCC_CONST_MIN) begin
            len = BCC_CONST_MIN;
        end
        bcc_code_len = len;
    endfunction
endpackage

// file: design/bcc_cycle_timer.sv
// Bus cycle timer: counts core-clock periods of one external bus cycle
`timescale 1ns/100ps
`default_nettype none
module bcc_cycle_timer
    import bcc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Control
    input  wire logic       start,
    input  wire logic [2:0] length,
    input  wire logic       hold,
    input  wire logic       abort,
    // Status
    output logic            busy,
    output logic            last,
    output logic [2:0]      count
);
    logic [2:0] next_count;
    logic       next_busy;

    // Last period ends the cycle unless held by a stall
    assign last = busy && (count == 3'h1) && !hold;

    always_comb begin
        next_count = count;
        next_busy  = busy;
        if (busy && abort) begin
            next_busy  = 1'b0;
            next_count = 3'h0;
        end else if (busy) begin
            if (last) begin
                next_busy  = 1'b0;
                next_count = 3'h0;
            end else if (count != 3'h1) begin
                next_count = count - 3'h1;
            end
        end else if (start) begin
            next_busy  = 1'b1;
            next_count = length;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count <= 3'h0;
            busy  <= 1'b0;
        end else begin
            count <= next_count;
            busy  <= next_busy;
        end
    end
endmodule // bcc_cycle_timer
`default_nettype wire

// file: design/bcc_bus_ctrl.sv
// Bus cycle control: control register and multiplexed external bus sequencer
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// R01 - Data writes go straight to the target, never through queue or cache.
// R02 - One write length applies to every address.
// R03 - Queue and cache enables writable by software at any time.
// R04 - After reset queue and cache are both enabled.
// R05 - Control register resets to 0xeb: six-period cycles, both enables set.
// R06 - Bit 7 enables prefetch queue, bit 6 enables branch cache.
// R07 - Bits 5:4 give write length 4 to 7 periods.
// R08 - Bits 3:2 give data read length 4 to 7 periods.
// R09 - Bits 1:0 give code length 3 to 6, constant reads at least 4.
// R10 - Code reads stretch while the prefetch queue stalls.
// R11 - At 40 MHz fast mode software programs 5 or 4 periods.
// R12 - At 40 MHz low-power mode software programs 6 or 5 periods.
// R13 - At 20 MHz and below software programs 3 code, 4 data periods.
// R14 - Eight data lines share the low address; latch strobe marks address phase.
// R15 - Fetched code enters the queue; constants and data bypass it.
// R16 - A code fetch in progress may be aborted when no longer needed.
// R17 - New settings apply from the next cycle; running cycle keeps its length.
module bcc_bus_ctrl
    import bcc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Special function register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    // Core request
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_kind,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    input  wire logic        pfq_stall,
    input  wire logic        fetch_abort,
    output logic             req_done,
    output logic [7:0]       core_rdata,
    output logic             core_rdata_valid,
    output logic [7:0]       pfq_rdata,
    output logic             pfq_rdata_valid,
    output logic             prefetch_queue_enable,
    output logic             branch_cache_enable,
    // External bus
    input  wire logic [7:0]  ad_in,
    output logic [7:0]       ad_out,
    output logic             ad_oe,
    output logic [15:8]      addr_high,
    output logic             addr_latch,
    output logic             code_read_strobe_n,
    output logic             rd_n,
    output logic             wr_n
);
    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [7:0] bus_cycle_control;
    logic [7:0] next_bus_cycle_control;

    always_comb begin
        next_bus_cycle_control = bus_cycle_control;
        if (sfr_wr && sfr_addr == BCC_REG_OFFSET) begin
            next_bus_cycle_control = sfr_wdata; // R03
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_cycle_control <= BCC_REG_RESET; // R04 R05
        end else begin
            bus_cycle_control <= next_bus_cycle_control;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    typedef enum logic [2:0] {
        BCC_ST_IDLE = 3'b001,
        BCC_ST_ADDR = 3'b010,
        BCC_ST_DATA = 3'b100
    } bcc_state_e;

    bcc_state_e state;
    bcc_state_e next_state;
    logic [2:0] kind;
    logic [2:0] next_kind;
    logic [2:0] cyc_len;
    logic       t_start;
    logic       t_busy;
    logic       t_last;
    logic [2:0] t_count;
    logic       is_code;
    logic       t_hold;
    logic       t_abort;

    // Length latched at start, so a later write cannot change it
    always_comb begin
        unique case (req_kind)
            BCC_KIND_WRITE: cyc_len = bcc_data_len(bus_cycle_control[BCC_WR_LSB +: 2]);    // R02 R07
            BCC_KIND_READ:  cyc_len = bcc_data_len(bus_cycle_control[BCC_RD_LSB +: 2]);    // R08
            BCC_KIND_CONST: cyc_len = bcc_code_len(bus_cycle_control[BCC_CODE_LSB +: 2],
                                                   1'b1);                                  // R09
            default:        cyc_len = bcc_code_len(bus_cycle_control[BCC_CODE_LSB +: 2],
                                                   1'b0);                                  // R09
        endcase
    end

    assign t_start = (state == BCC_ST_IDLE) && req_valid; // R17
    assign is_code = (kind == BCC_KIND_FETCH) || (kind == BCC_KIND_CONST);
    assign t_hold  = is_code && pfq_stall;                // R10
    // Abort only counts inside a cycle; a stale kind must not fake a done pulse
    assign t_abort = (state != BCC_ST_IDLE) && (kind == BCC_KIND_FETCH) && fetch_abort; // R16

    bcc_cycle_timer u_timer (
        .mclk   (mclk),
        .resetn (resetn),
        .start  (t_start),
        .length (cyc_len),
        .hold   (t_hold),
        .abort  (t_abort),
        .busy   (t_busy),
        .last   (t_last),
        .count  (t_count)
    );

    always_comb begin
        next_state = state;
        next_kind  = kind;
        unique case (state)
            BCC_ST_IDLE: if (t_start) begin
                next_state = BCC_ST_ADDR;
                next_kind  = req_kind;
            end
            BCC_ST_ADDR: next_state = t_abort ? BCC_ST_IDLE : BCC_ST_DATA;
            BCC_ST_DATA: if (t_last || t_abort) begin
                next_state = BCC_ST_IDLE;
            end
            default: next_state = BCC_ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    logic [7:0]  next_ad_out;
    logic        next_ad_oe;
    logic [15:8] next_addr_high;
    logic        next_latch;
    logic        next_code_read_strobe_n;
    logic        next_rd_n;
    logic        next_wr_n;
    logic        next_done;
    logic        next_core_v;
    logic        next_pfq_v;
    logic [7:0]  wdata_hold;
    logic [7:0]  next_wdata_hold;
    logic        ending;

    assign ending = (state == BCC_ST_DATA) && t_last;

    always_comb begin
        next_ad_out     = ad_out;
        next_ad_oe      = ad_oe;
        next_addr_high  = addr_high;
        next_latch      = 1'b0;
        next_code_read_strobe_n     = code_read_strobe_n;
        next_rd_n       = rd_n;
        next_wr_n       = wr_n;
        next_wdata_hold = wdata_hold;
        next_done       = 1'b0;
        next_core_v     = 1'b0;
        next_pfq_v      = 1'b0;
        if (t_start) begin
            // Address phase: low byte on shared lines, latch strobe high
            next_ad_out     = req_addr[7:0];  // R14
            next_ad_oe      = 1'b1;
            next_addr_high  = req_addr[15:8];
            next_latch      = 1'b1;           // R14
            next_wdata_hold = req_wdata;
        end else if (state == BCC_ST_ADDR && !t_abort) begin
            unique case (kind)
                BCC_KIND_WRITE: begin
                    next_ad_out = wdata_hold; // R01
                    next_wr_n   = 1'b0;
                end
                BCC_KIND_READ: begin
                    next_ad_oe = 1'b0;
                    next_rd_n  = 1'b0;
                end
                default: begin
                    next_ad_oe  = 1'b0;
                    next_code_read_strobe_n = 1'b0;
                end
            endcase
        end else if (ending || t_abort) begin
            next_ad_oe  = 1'b0;
            next_code_read_strobe_n = 1'b1;
            next_rd_n   = 1'b1;
            next_wr_n   = 1'b1;
            next_done   = 1'b1;
            if (ending && kind == BCC_KIND_FETCH) begin
                next_pfq_v = 1'b1;    // R15
            end else if (ending && kind != BCC_KIND_WRITE) begin
                next_core_v = 1'b1;   // R15
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state                 <= BCC_ST_IDLE;
            kind                  <= 3'h0;
            ad_out                <= 8'h00;
            ad_oe                 <= 1'b0;
            addr_high             <= 8'h00;
            addr_latch            <= 1'b0;
            code_read_strobe_n    <= 1'b1;
            rd_n                  <= 1'b1;
            wr_n                  <= 1'b1;
            wdata_hold            <= 8'h00;
            req_done              <= 1'b0;
            core_rdata            <= 8'h00;
            core_rdata_valid      <= 1'b0;
            pfq_rdata             <= 8'h00;
            pfq_rdata_valid       <= 1'b0;
            sfr_rdata             <= 8'h00;
            prefetch_queue_enable <= 1'b1;
            branch_cache_enable   <= 1'b1;
        end else begin
            state                 <= next_state;
            kind                  <= next_kind;
            ad_out                <= next_ad_out;
            ad_oe                 <= next_ad_oe;
            addr_high             <= next_addr_high;
            addr_latch            <= next_latch;
            code_read_strobe_n    <= next_code_read_strobe_n;
            rd_n                  <= next_rd_n;
            wr_n                  <= next_wr_n;
            wdata_hold            <= next_wdata_hold;
            req_done              <= next_done;
            core_rdata_valid      <= next_core_v;
            pfq_rdata_valid       <= next_pfq_v;
            if (next_core_v) core_rdata <= ad_in;
            if (next_pfq_v)  pfq_rdata  <= ad_in;
            sfr_rdata             <= (sfr_addr == BCC_REG_OFFSET) ? next_bus_cycle_control
                                                                   : 8'h00;
            prefetch_queue_enable <= next_bus_cycle_control[BCC_PFQ_BIT]; // R06
            branch_cache_enable   <= next_bus_cycle_control[BCC_BC_BIT];  // R06
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_RESET_VALUE: assert property (@(posedge mclk) $rose(resetn) |->
        bus_cycle_control == 8'heb) else $error("Control reset value wrong"); // R05
    AST_ENABLES: assert property (@(posedge mclk) disable iff (!resetn)
        prefetch_queue_enable == bus_cycle_control[7] &&
        branch_cache_enable == bus_cycle_control[6]) else $error("Enable bits mismatch"); // R06
    AST_SFR_WRITE: assert property (@(posedge mclk) disable iff (!resetn)
        sfr_wr && sfr_addr == 8'h9d |=> bus_cycle_control == $past(sfr_wdata))
        else $error("Register write lost"); // R03
    AST_WRITE_LEN: assert property (@(posedge mclk) disable iff (!resetn)
        t_start && req_kind == BCC_KIND_WRITE |=>
        t_count == 3'h4 + {1'b0, $past(bus_cycle_control[5:4])})
        else $error("Write length wrong"); // R07
    AST_READ_LEN: assert property (@(posedge mclk) disable iff (!resetn)
        t_start && req_kind == BCC_KIND_READ |=>
        t_count == 3'h4 + {1'b0, $past(bus_cycle_control[3:2])})
        else $error("Read length wrong"); // R08
    AST_CONST_MIN: assert property (@(posedge mclk) disable iff (!resetn)
        t_start && req_kind == BCC_KIND_CONST |=> t_count >= 3'h4)
        else $error("Constant read too short"); // R09
    AST_STALL_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
        t_busy && t_count == 3'h1 && is_code && pfq_stall && !t_abort |=> t_busy)
        else $error("Code cycle ended during stall"); // R10
    AST_WRITE_NO_PFQ: assert property (@(posedge mclk) disable iff (!resetn)
        kind == BCC_KIND_WRITE && ending |=> !pfq_rdata_valid && !core_rdata_valid)
        else $error("Write routed to queue"); // R01
    AST_LATCH_PHASE: assert property (@(posedge mclk) disable iff (!resetn)
        addr_latch |-> ad_oe && wr_n && rd_n && code_read_strobe_n)
        else $error("Strobe during address phase"); // R14
    AST_FETCH_ROUTE: assert property (@(posedge mclk) disable iff (!resetn)
        ending && kind == BCC_KIND_FETCH |=> pfq_rdata_valid && !core_rdata_valid)
        else $error("Fetch not routed to queue"); // R15
    AST_LEN_STABLE: assert property (@(posedge mclk) disable iff (!resetn)
        t_busy && !t_hold && t_count > 3'h1 && !t_abort |=> t_count == $past(t_count) - 3'h1)
        else $error("Running cycle length changed"); // R17
endmodule // bcc_bus_ctrl
`default_nettype wire

// file: test/bcc_ext_mem.sv
// Far-side bus device model: latches the address, serves reads, stores writes
`timescale 1ns/100ps
`default_nettype none
module bcc_ext_mem (
    // Clock
    input  wire logic        mclk,
    // Bus from the device
    input  wire logic [7:0]  ad_out,
    input  wire logic        ad_oe,
    input  wire logic [15:8] addr_high,
    input  wire logic        addr_latch,
    input  wire logic        code_read_strobe_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    // Data back to the device
    output logic [7:0]       ad_in,
    // Observation
    output logic [15:0]      seen_addr,
    output logic [7:0]       seen_wdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] junk;
    logic       rd_act;

    assign rd_act = !rd_n || !code_read_strobe_n;
    // Released lines alternate between the inverse of the last byte read and that byte
    assign ad_in  = rd_act ? mem[seen_addr] : junk;

    initial begin
        seen_addr  = 16'h0000;
        seen_wdata = 8'h00;
        junk       = 8'h00;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
        end
    end

    always @(posedge mclk) begin
        junk <= rd_act ? ~ad_in : ~junk;
        if (addr_latch && ad_oe) begin
            seen_addr <= {addr_high, ad_out};
        end
        if (!wr_n && ad_oe) begin
            mem[seen_addr] <= ad_out;
            seen_wdata     <= ad_out;
        end
    end
endmodule // bcc_ext_mem
`default_nettype wire

// file: test/mcu_bus_cycle_timing_control_test.sv
// Testbench: register access, cycle lengths, stall, abort and reset of the bus controller
`timescale 1ns/100ps
`default_nettype none
module mcu_bus_cycle_timing_control_test;
    import bcc_pkg::*;
    logic        mclk = 1'b0, resetn = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic        sfr_wr = 1'b0, req_valid = 1'b0, pfq_stall = 1'b0, fetch_abort = 1'b0;
    logic [2:0]  req_kind = 3'h1;
    logic [15:0] req_addr = 16'h0000, seen_addr;
    logic [7:0]  req_wdata = 8'h00, core_rdata, pfq_rdata, ad_in, ad_out, seen_wdata;
    logic        req_done, core_rdata_valid, pfq_rdata_valid, prefetch_queue_enable;
    logic        branch_cache_enable, ad_oe, addr_latch, code_read_strobe_n, rd_n, wr_n;
    logic [15:8] addr_high;
    int          fail_count = 0, cmp_count = 0, cycles = 0;
    int          stall_len = 0, abort_at = 0, mid_en = 0;
    logic [7:0]  mid_val = 8'h00;

    bcc_bus_ctrl i_dut (.mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .req_valid(req_valid),
        .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
        .pfq_stall(pfq_stall), .fetch_abort(fetch_abort), .req_done(req_done),
        .core_rdata(core_rdata), .core_rdata_valid(core_rdata_valid), .pfq_rdata(pfq_rdata),
        .pfq_rdata_valid(pfq_rdata_valid), .prefetch_queue_enable(prefetch_queue_enable),
        .branch_cache_enable(branch_cache_enable), .ad_in(ad_in), .ad_out(ad_out),
        .ad_oe(ad_oe), .addr_high(addr_high), .addr_latch(addr_latch),
        .code_read_strobe_n(code_read_strobe_n), .rd_n(rd_n), .wr_n(wr_n));

    bcc_ext_mem i_mem (.mclk(mclk), .ad_out(ad_out), .ad_oe(ad_oe), .addr_high(addr_high),
        .addr_latch(addr_latch), .code_read_strobe_n(code_read_strobe_n), .rd_n(rd_n),
        .wr_n(wr_n), .ad_in(ad_in), .seen_addr(seen_addr), .seen_wdata(seen_wdata));

    always #25 mclk = ~mclk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge mclk);
        sfr_wr    = 1'b0;
    endtask

    task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        @(negedge mclk);
        check("reg_read", {8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    // Request held until the taking edge; counts negedges until done
    task automatic bus_cycle(input logic [2:0] k, input logic [15:0] a, input logic [7:0] wd,
                             output int n, output logic [7:0] d, output logic cv, output logic pv);
        req_kind  = k;
        req_addr  = a;
        req_wdata = wd;
        req_valid = 1'b1;
        pfq_stall = stall_len > 0;
        n  = 0;
        cv = 1'b0;
        pv = 1'b0;
        d  = 8'h00;
        do begin
            @(negedge mclk);
            n++;
            req_valid   = 1'b0;
            sfr_wr      = mid_en != 0 && n == 1;
            sfr_addr    = BCC_REG_OFFSET;
            sfr_wdata   = mid_val;
            pfq_stall   = n < stall_len;
            fetch_abort = n == abort_at;
            cv |= core_rdata_valid;
            pv |= pfq_rdata_valid;
            if (core_rdata_valid === 1'b1) begin
                d = core_rdata;
            end
            if (pfq_rdata_valid === 1'b1) begin
                d = pfq_rdata;
            end
        end while (req_done !== 1'b1 && n < 60);
        fetch_abort = 1'b0;
        sfr_wr      = 1'b0;
    endtask

    task automatic run(input logic [2:0] k, input logic [15:0] a, input logic [7:0] wd,
                       input int en, input logic [7:0] ed);
        int n;
        logic [7:0] d;
        logic cv, pv;
        bus_cycle(k, a, wd, n, d, cv, pv);
        check("cycle_len", 16'(n), 16'(en));
        check("seen_addr", seen_addr, a);
        if (k == BCC_KIND_WRITE) begin
            check("wr_data", {8'h00, seen_wdata}, {8'h00, wd});
        end else begin
            check("rd_data", {8'h00, d}, {8'h00, ed});
        end
        check("core_valid", 16'(cv), 16'(k == BCC_KIND_CONST || k == BCC_KIND_READ));
        check("queue_valid", 16'(pv), 16'(k == BCC_KIND_FETCH));
    endtask

    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        reg_check(BCC_REG_OFFSET, 8'heb);
        check("enables", {prefetch_queue_enable, branch_cache_enable}, 16'h3);
        reg_check(8'h9c, 8'h00);
        $display("test_reset done");
    endtask

    task automatic test_enables();
        logic [7:0] v [4] = '{8'h00, 8'h40, 8'h80, 8'hff};
        foreach (v[i]) begin
            reg_write(BCC_REG_OFFSET, v[i]);
            check("enables", {prefetch_queue_enable, branch_cache_enable}, v[i][7:6]);
            reg_check(BCC_REG_OFFSET, v[i]);
        end
        $display("test_enables done");
    endtask

    task automatic test_lengths();
        for (int c = 0; c < 4; c++) begin
            reg_write(BCC_REG_OFFSET, {2'b11, 2'(c), 2'(c), 2'(c)});
            run(BCC_KIND_WRITE, 16'h0012, 8'ha0 + 8'(c), c + 5, 8'h00);
            run(BCC_KIND_WRITE, 16'hf3c4, 8'h3c, c + 5, 8'h00);
            run(BCC_KIND_READ, 16'h0012, 8'h00, c + 5, 8'ha0 + 8'(c));
            run(BCC_KIND_FETCH, 16'h4d21, 8'h00, c + 4, pat(16'h4d21));
            run(BCC_KIND_CONST, 16'h80f7, 8'h00, (c == 0) ? 5 : c + 4, pat(16'h80f7));
        end
        $display("test_lengths done");
    endtask

    task automatic test_late_write();
        reg_write(BCC_REG_OFFSET, 8'hff);
        mid_en  = 1;
        mid_val = 8'hc0;
        run(BCC_KIND_READ, 16'h2345, 8'h00, 8, pat(16'h2345));
        mid_en  = 0;
        run(BCC_KIND_READ, 16'h2345, 8'h00, 5, pat(16'h2345));
        $display("test_late_write done");
    endtask

    task automatic test_stall_abort();
        int n;
        logic [7:0] d;
        logic cv, pv;
        reg_write(BCC_REG_OFFSET, 8'heb);
        stall_len = 20;
        bus_cycle(BCC_KIND_FETCH, 16'h1357, 8'h00, n, d, cv, pv);
        check("stall_len", 16'(n >= 21 && n <= 23), 16'h1);
        check("stall_data", {8'h00, d}, {8'h00, pat(16'h1357)});
        run(BCC_KIND_READ, 16'h1357, 8'h00, 7, pat(16'h1357));
        stall_len = 0;
        abort_at  = 2;
        bus_cycle(BCC_KIND_FETCH, 16'h2468, 8'h00, n, d, cv, pv);
        check("abort_len", 16'(n > 2 && n <= 4), 16'h1);
        check("abort_valid", 16'(pv), 16'h0);
        abort_at  = 0;
        // Abort request while idle must not end a cycle that is not there
        @(negedge mclk);
        fetch_abort = 1'b1;
        @(negedge mclk);
        check("idle_abort", {15'h0000, req_done}, 16'h0000);
        fetch_abort = 1'b0;
        $display("test_stall_abort done");
    endtask

    always @(posedge mclk) begin
        cycles++;
        // Whole run needs well under a thousand cycles
        if (cycles >= 5000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        test_reset();
        test_enables();
        test_lengths();
        test_late_write();
        test_stall_abort();
        reg_write(BCC_REG_OFFSET, 8'h00);
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        test_reset();
        end_sim();
    end
endmodule // mcu_bus_cycle_timing_control_test
`default_nettype wire
